// [hw/mfc_config_regs.sv]
// Behaviour
// - fan mode bit: 1 level, 0 counting
// - count mode prescale 1,2,4,8 by code
// - level mode: 01 active low, 00 high
// - bit6 only set: pin is overtemp alarm
// - bit7 only: reset; both set: pin off
// - overtemp status bit reads pin in alarm mode, else 0; read-only
// - polarity bit: 1 active high, 0 low
// - mode bit: 1 one-shot, 0 comparator
// - resolution bit: 1 eleven bits, 0 eight
// - bits 7:4 hold low temperature bits
// - continuous bit set: no inserted delay
// - else delay 1.42 ms times (8N+6)
// - N 0..255, ignored when continuous
// - mask register bit7 also picks one-shot
`timescale 1ns/1ns
`default_nettype none
`include "mfc_consts.svh"

module mfc_config_regs #(
	parameter int UNIT_CYCLES = `MFC_DLY_UNIT_NS / `MFC_CLK_NS
) (
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	input  wire logic       i_wr_en,
	input  wire logic       i_rd_en,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wr_data,
	input  wire logic [7:0] i_count_n,
	input  wire logic       i_monitor_done,
	input  wire logic       i_over_limit,
	input  wire logic       i_alarm_ack,
	input  wire logic       i_mask2_one_shot,
	input  wire logic       i_reset_request,
	input  wire logic       i_temp_wr,
	input  wire logic [3:0] i_temp_frac,
	input  wire logic       i_tach_input_one,
	input  wire logic       i_tach_input_two,
	input  wire logic       i_shared_alarm_reset_pin,
	output logic [7:0]      o_rd_data,
	output logic            o_cycle_start,
	output logic            o_temp_hires,
	output logic [1:0]      o_tach_pulse,
	output logic [1:0]      o_tach_active,
	output logic            o_shared_alarm_reset_pin,
	output logic            o_shared_alarm_reset_pin_oe_n
);
	localparam int UNIT_W = $clog2(UNIT_CYCLES + 1);
	// full-width reset words, so active copies take only their own fields
	localparam logic [7:0] RST_OS_CFG    = `MFC_RST_OS_CFG;
	localparam logic [7:0] RST_CONV_RATE = `MFC_RST_CONV_RATE;

	logic [7:0]           fan_pin_ff;
	logic [7:0]           os_cfg_ff;
	logic [7:0]           conv_rate_ff;
	logic [7:0]           act_fan_pin_ff;
	logic [3:0]           act_os_ff;
	logic                 act_continuous_ff;
	logic [10:0]          act_units_ff;
	mfc_pkg::mfc_seq_e    seq_ff;
	logic [UNIT_W-1:0]    unit_cnt_ff;
	logic [10:0]          units_left_ff;
	logic                 alarm_ff;
	logic                 over_d_ff;
	mfc_pkg::mfc_pin_mode_e pin_mode;
	mfc_pkg::mfc_tach_cfg_s tach_cfg [2];
	logic [1:0]           tach_in;
	logic                 one_shot;
	logic                 in_alarm_mode;

	// alarm or reset function, or off when both or neither set
	always_comb begin
		case ({act_fan_pin_ff[`MFC_FP_RST_EN],
		              act_fan_pin_ff[`MFC_FP_OS_EN]})
			2'h1:    pin_mode = mfc_pkg::MFC_PIN_ALARM;
			2'h2:    pin_mode = mfc_pkg::MFC_PIN_RESET;
			default: pin_mode = mfc_pkg::MFC_PIN_OFF;
		endcase
	end

	// status bit tracks pin in alarm mode (live config)
	assign in_alarm_mode = fan_pin_ff[`MFC_FP_OS_EN] &
	                       ~fan_pin_ff[`MFC_FP_RST_EN];

	// host writes land in the shadow copies at once
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fan_pin_ff   <= `MFC_RST_FAN_PIN;
			conv_rate_ff <= `MFC_RST_CONV_RATE;
		end else if (i_wr_en) begin
			if (i_addr == `MFC_ADDR_FAN_PIN)
				fan_pin_ff <= i_wr_data;
			// upper bits stored as written, host keeps them zero
			if (i_addr == `MFC_ADDR_CONV_RATE)
				conv_rate_ff <= i_wr_data;
		end
	end

	// overtemp config; conversion result beats a host write
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			os_cfg_ff <= `MFC_RST_OS_CFG;
		end else begin
			if (i_wr_en && i_addr == `MFC_ADDR_OS_CFG) begin
				os_cfg_ff[`MFC_OS_FRAC_MSB:`MFC_OS_POL] <=
					i_wr_data[`MFC_OS_FRAC_MSB:`MFC_OS_POL];
			end
			// fraction bits, eight-bit mode keeps only the top one
			if (i_temp_wr) begin
				if (act_os_ff[`MFC_OS_HIRES]) begin
					os_cfg_ff[`MFC_OS_FRAC_MSB:`MFC_OS_FRAC_LSB] <= i_temp_frac;
				end else begin
					os_cfg_ff[`MFC_OS_FRAC_MSB:`MFC_OS_FRAC_LSB] <=
						{i_temp_frac[3], 3'h0};
				end
			end
			os_cfg_ff[`MFC_OS_STATUS] <= in_alarm_mode ?
				i_shared_alarm_reset_pin : 1'b0;
		end
	end

	// active copies follow shadows only at cycle start
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			act_fan_pin_ff    <= `MFC_RST_FAN_PIN;
			act_os_ff         <= RST_OS_CFG[`MFC_OS_HIRES:`MFC_OS_STATUS];
			act_continuous_ff <= RST_CONV_RATE[`MFC_CR_CONTINUOUS];
			act_units_ff      <= `MFC_DLY_ADD;
		end else if (seq_ff == mfc_pkg::MFC_SEQ_START) begin
			act_fan_pin_ff    <= fan_pin_ff;
			act_os_ff         <= os_cfg_ff[`MFC_OS_HIRES:`MFC_OS_STATUS];
			act_continuous_ff <= conv_rate_ff[`MFC_CR_CONTINUOUS];
			act_units_ff <= (11'(i_count_n) << `MFC_DLY_MUL_SHIFT)
			                + `MFC_DLY_ADD;
		end
	end

	// delay between monitoring cycles, counted in 1.42 ms units
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			seq_ff        <= mfc_pkg::MFC_SEQ_START;
			unit_cnt_ff   <= '0;
			units_left_ff <= 11'h000;
		end else begin
			case (seq_ff)
				mfc_pkg::MFC_SEQ_IDLE: begin
					if (i_monitor_done) begin
						unit_cnt_ff   <= '0;
						units_left_ff <= act_units_ff;
						seq_ff <= act_continuous_ff ? mfc_pkg::MFC_SEQ_START
						                            : mfc_pkg::MFC_SEQ_WAIT;
					end
				end
				mfc_pkg::MFC_SEQ_WAIT: begin
					if (unit_cnt_ff == UNIT_W'(UNIT_CYCLES - 1)) begin
						unit_cnt_ff   <= '0;
						units_left_ff <= units_left_ff - 11'h001;
						if (units_left_ff == 11'h001)
							seq_ff <= mfc_pkg::MFC_SEQ_START;
					end else begin
						unit_cnt_ff <= unit_cnt_ff + UNIT_W'(1);
					end
				end
				mfc_pkg::MFC_SEQ_START: seq_ff <= mfc_pkg::MFC_SEQ_IDLE;
				default:                seq_ff <= mfc_pkg::MFC_SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_cycle_start <= 1'b0;
			o_temp_hires  <= 1'b0;
		end else begin
			o_cycle_start <= (seq_ff == mfc_pkg::MFC_SEQ_START);
			o_temp_hires  <= act_os_ff[`MFC_OS_HIRES];
		end
	end

	// mode bit, mask register bit also selects one-shot
	assign one_shot = act_os_ff[`MFC_OS_ONE_SHOT] | i_mask2_one_shot;

	// alarm: comparator follows limit, one-shot latches until acknowledged
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			alarm_ff  <= 1'b0;
			over_d_ff <= 1'b0;
		end else begin
			over_d_ff <= i_over_limit;
			if (!one_shot)
				alarm_ff <= i_over_limit;
			else if (i_over_limit && !over_d_ff)
				alarm_ff <= 1'b1; // new event wins over a same-cycle ack
			else if (i_alarm_ack)
				alarm_ff <= 1'b0;
		end
	end

	// pin drive; oe_n low while driving
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_shared_alarm_reset_pin      <= 1'b1;
			o_shared_alarm_reset_pin_oe_n <= 1'b1;
		end else begin
			case (pin_mode)
				mfc_pkg::MFC_PIN_ALARM: begin
					o_shared_alarm_reset_pin <=
						alarm_ff ~^ act_os_ff[`MFC_OS_POL];
					o_shared_alarm_reset_pin_oe_n <= 1'b0;
				end
				mfc_pkg::MFC_PIN_RESET: begin
					o_shared_alarm_reset_pin      <= ~i_reset_request;
					o_shared_alarm_reset_pin_oe_n <= 1'b0;
				end
				default: begin
					o_shared_alarm_reset_pin      <= 1'b1;
					o_shared_alarm_reset_pin_oe_n <= 1'b1;
				end
			endcase
		end
	end

	// registered read port; unmapped offsets read zero
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rd_data <= 8'h00;
		end else if (i_rd_en) begin
			case (i_addr)
				`MFC_ADDR_FAN_PIN:   o_rd_data <= fan_pin_ff;
				`MFC_ADDR_OS_CFG:    o_rd_data <= os_cfg_ff;
				`MFC_ADDR_CONV_RATE: o_rd_data <= conv_rate_ff;
				default:             o_rd_data <= 8'h00;
			endcase
		end
	end

	// per-fan config from the active copy, field bit order hi:lo
	assign tach_cfg[0] = '{act_fan_pin_ff[`MFC_FP_F1_MODE],
	                       {act_fan_pin_ff[`MFC_FP_F1_HI],
	                        act_fan_pin_ff[`MFC_FP_F1_LO]}};
	assign tach_cfg[1] = '{act_fan_pin_ff[`MFC_FP_F2_MODE],
	                       {act_fan_pin_ff[`MFC_FP_F2_HI],
	                        act_fan_pin_ff[`MFC_FP_F2_LO]}};
	assign tach_in = {i_tach_input_two, i_tach_input_one};

	// one conditioner per fan input
	for (genvar g = 0; g < 2; g++) begin : g_fan
		mfc_tach_cond u_cond (
			.i_clk    (i_clk),
			.i_reset_n(i_reset_n),
			.i_cfg    (tach_cfg[g]),
			.i_tach   (tach_in[g]),
			.o_pulse  (o_tach_pulse[g]),
			.o_active (o_tach_active[g])
		);
	end

endmodule // mfc_config_regs
`default_nettype wire

// [hw/mfc_consts.svh]
`ifndef MFC_CONSTS_SVH
`define MFC_CONSTS_SVH

// register offsets on the internal register port
`define MFC_ADDR_FAN_PIN    8'h05
`define MFC_ADDR_OS_CFG     8'h06
`define MFC_ADDR_CONV_RATE  8'h07

// reset values (overtemp config: status bit reads the pin only in alarm mode)
`define MFC_RST_FAN_PIN     8'h14
`define MFC_RST_OS_CFG      8'h01
`define MFC_RST_CONV_RATE   8'h40

// fan and pin config fields
`define MFC_FP_F1_MODE      0
`define MFC_FP_F2_MODE      1
`define MFC_FP_F1_HI        2
`define MFC_FP_F1_LO        3
`define MFC_FP_F2_HI        4
`define MFC_FP_F2_LO        5
`define MFC_FP_OS_EN        6
`define MFC_FP_RST_EN       7

// overtemp config fields
`define MFC_OS_STATUS       0
`define MFC_OS_POL          1
`define MFC_OS_ONE_SHOT     2
`define MFC_OS_HIRES        3
`define MFC_OS_FRAC_LSB     4
`define MFC_OS_FRAC_MSB     7

// conversion rate field
`define MFC_CR_CONTINUOUS   0

// speed codes
`define MFC_CODE_DIV1       2'h0
`define MFC_CODE_ACT_LOW    2'h1

// delay = unit * (8 * n + 6), unit in ns, clock period in ns
`define MFC_DLY_UNIT_NS     1420000
`define MFC_CLK_NS          8
`define MFC_DLY_MUL_SHIFT   3
`define MFC_DLY_ADD         11'h006

`endif

// [hw/mfc_pkg.sv]
package mfc_pkg;

	// one tach input's setup
	typedef struct packed {
		logic       level_mode;
		logic [1:0] code;
	} mfc_tach_cfg_s;

	// function of the shared alarm/reset pin
	typedef enum logic [1:0] {
		MFC_PIN_OFF   = 2'h0,
		MFC_PIN_ALARM = 2'h1,
		MFC_PIN_RESET = 2'h2
	} mfc_pin_mode_e;

	// monitoring delay sequencer, gray along idle -> wait -> start
	typedef enum logic [1:0] {
		MFC_SEQ_IDLE  = 2'h0,
		MFC_SEQ_WAIT  = 2'h1,
		MFC_SEQ_START = 2'h3
	} mfc_seq_e;

endpackage

// [hw/mfc_tach_cond.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mfc_consts.svh"

module mfc_tach_cond (
	input  wire logic                   i_clk,
	input  wire logic                   i_reset_n,
	input  wire mfc_pkg::mfc_tach_cfg_s i_cfg,
	input  wire logic                   i_tach,
	output logic                        o_pulse,
	output logic                        o_active
);
	logic       tach_d_ff;
	logic [2:0] div_ff;
	logic [2:0] div_mask;
	logic       rise;

	assign rise = i_tach & ~tach_d_ff;
	// divisor 1,2,4,8 -> wrap mask 0,1,3,7
	assign div_mask = 3'((4'h1 << i_cfg.code) - 4'h1);

	// edge history
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tach_d_ff <= 1'b0;
		end else begin
			tach_d_ff <= i_tach;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_ff  <= 3'h0;
			o_pulse <= 1'b0;
		end else begin
			o_pulse <= 1'b0;
			if (i_cfg.level_mode) begin
				div_ff <= 3'h0;
			end else if (rise) begin
				if ((div_ff & div_mask) == div_mask) begin
					div_ff  <= 3'h0;
					o_pulse <= 1'b1;
				end else begin
					div_ff <= div_ff + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_active <= 1'b0;
		end else if (!i_cfg.level_mode) begin
			o_active <= 1'b0;
		end else if (i_cfg.code == `MFC_CODE_ACT_LOW) begin
			o_active <= ~i_tach;
		end else begin
			o_active <= i_tach; // other codes read as active high
		end
	end

endmodule // mfc_tach_cond
`default_nettype wire

// [test/mfc_checker.sv]
`timescale 1ns/1ns
`default_nettype none
// port timing checks on the config bank
module mfc_checker (
	input wire logic       i_clk,
	input wire logic       i_reset_n,
	input wire logic       i_rd_en,
	input wire logic [7:0] i_addr,
	input wire logic       i_tach_input_one,
	input wire logic       i_tach_input_two,
	input wire logic [7:0] o_rd_data,
	input wire logic       o_cycle_start,
	input wire logic       o_temp_hires,
	input wire logic [1:0] o_tach_pulse,
	input wire logic       o_shared_alarm_reset_pin_oe_n
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);
	// active config may only move close to a cycle start
	sequence s_near_start;
		o_cycle_start || $past(o_cycle_start) || $past(o_cycle_start, 2);
	endsequence
	sequence s_bad_read;
		i_rd_en && (i_addr < 8'h05 || i_addr > 8'h07);
	endsequence
	a_unmapped_zero: assert property (
		s_bad_read |=> o_rd_data == 8'h00)
		else $error("unmapped read not zero");
	a_rd_data_holds: assert property (
		!$past(i_rd_en) |-> $stable(o_rd_data))
		else $error("read data moved without a read");
	a_start_one_cycle: assert property (
		o_cycle_start |=> !o_cycle_start)
		else $error("cycle start longer than one cycle");
	a_hires_at_start: assert property (
		$changed(o_temp_hires) |-> s_near_start)
		else $error("resolution changed between cycles");
	a_pin_mode_at_start: assert property (
		$changed(o_shared_alarm_reset_pin_oe_n) |-> s_near_start)
		else $error("pin mode changed between cycles");
	a_tach_one_edge: assert property (
		$rose(o_tach_pulse[0]) |-> $past(i_tach_input_one))
		else $error("fan one pulse without rising edge");
	a_tach_two_edge: assert property (
		$rose(o_tach_pulse[1]) |-> $past(i_tach_input_two))
		else $error("fan two pulse without rising edge");
	a_tach_pulse_short: assert property (
		o_tach_pulse[0] |=> !o_tach_pulse[0])
		else $error("fan one pulse too long");
endmodule // mfc_checker
bind mfc_config_regs mfc_checker u_chk (.i_clk, .i_reset_n, .i_rd_en,
	.i_addr, .i_tach_input_one, .i_tach_input_two, .o_rd_data,
	.o_cycle_start, .o_temp_hires, .o_tach_pulse,
	.o_shared_alarm_reset_pin_oe_n);
`default_nettype wire

// [test/mfc_host.sv]
`timescale 1ns/1ns
`default_nettype none
// host on the register port, changes its lines on falling edges
module mfc_host (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rd_data,
	output logic            o_wr_en,
	output logic            o_rd_en,
	output logic [7:0]      o_addr,
	output logic [7:0]      o_wr_data
);
	// idle lines start low
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 8'h00;
		o_wr_data = 8'h00;
	end
	// one write; released lines show the inverse so no stale value passes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_wr_data = (a == 8'h07) ? (d & 8'h01) : d;
		o_wr_en = 1'b1;
		@(negedge i_clk);
		o_wr_en = 1'b0;
		o_addr = ~a;
		o_wr_data = ~o_wr_data;
	endtask
	// one read; data is taken a cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_rd_en = 1'b1;
		@(negedge i_clk);
		o_rd_en = 1'b0;
		o_addr = ~a;
		d = i_rd_data;
	endtask
endmodule // mfc_host
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam int UC = 4; // short delay unit keeps the run brief
	logic       clk = 1'b0, rst_n = 1'b0, done = 1'b0, over = 1'b0;
	logic       ack = 1'b0, m2 = 1'b0, rreq = 1'b0, twr = 1'b0;
	logic       t1 = 1'b0, t2 = 1'b0, wr_en, rd_en, cs, hires, pin, oe_n;
	logic [7:0] cnt_n = 8'h00, addr, wdat, rdat;
	logic [3:0] frac = 4'h0;
	logic [1:0] tp, ta;
	int         fail_count = 0, checked = 0, np = 0, np2 = 0, k;
	// pull-up on the shared pin while it is not driven
	wire        pin_w = oe_n ? 1'b1 : pin;
	// 125 MHz clock
	initial begin
		forever #4 clk = ~clk;
	end
	mfc_config_regs #(.UNIT_CYCLES(UC)) DUT (
		.i_clk(clk), .i_reset_n(rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en),
		.i_addr(addr), .i_wr_data(wdat), .i_count_n(cnt_n),
		.i_monitor_done(done), .i_over_limit(over), .i_alarm_ack(ack),
		.i_mask2_one_shot(m2), .i_reset_request(rreq), .i_temp_wr(twr),
		.i_temp_frac(frac), .i_tach_input_one(t1), .i_tach_input_two(t2),
		.i_shared_alarm_reset_pin(pin_w), .o_rd_data(rdat),
		.o_cycle_start(cs), .o_temp_hires(hires), .o_tach_pulse(tp),
		.o_tach_active(ta), .o_shared_alarm_reset_pin(pin),
		.o_shared_alarm_reset_pin_oe_n(oe_n));
	mfc_host u_host (.i_clk(clk), .i_rd_data(rdat), .o_wr_en(wr_en),
		.o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wdat));
	// counts one-cycle pulses of fan one
	always @(negedge clk) if (tp[0] === 1'b1) np++;
	// counts one-cycle pulses of fan two
	always @(negedge clk) if (tp[1] === 1'b1) np2++;
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.rd(a, d);
		chk(16'(d), 16'(e));
	endtask
	task automatic pk(input logic [7:0] e);
		repeat (2) @(negedge clk);
		chk(16'({oe_n, pin}), 16'(e));
	endtask
	// ends a monitoring cycle, k counts cycles until the next start
	task automatic cyc();
		@(negedge clk) done = 1'b1;
		@(negedge clk) done = 1'b0;
		k = 1;
		while (cs !== 1'b1 && k < 9000) begin
			@(negedge clk);
			k++;
		end
	endtask
	task automatic t_reset();
		rc(8'h05, 8'h14);
		rc(8'h06, 8'h00);
		rc(8'h07, 8'h40);
		rc(8'h08, 8'h00);
		u_host.wr(8'h08, 8'h5A);
		u_host.wr(8'h06, 8'h01);
		rc(8'h06, 8'h00);
		rc(8'h08, 8'h00);
	endtask
	task automatic t_rate();
		cnt_n = 8'hFF;
		cyc();
		chk(16'(k), 16'(2 + UC * 6));
		u_host.wr(8'h07, 8'hFF);
		cyc();
		chk(16'(k), 16'(2 + UC * 2046));
		rc(8'h07, 8'h01);
		cyc();
		chk(16'(k), 16'h0002);
		cnt_n = 8'h01;
		u_host.wr(8'h07, 8'h00);
		cyc();
		chk(16'(k), 16'h0002);
		cyc();
		chk(16'(k), 16'(2 + UC * 14));
		u_host.wr(8'h07, 8'h01);
		cyc();
	endtask
	// every speed code on fan one; fan two in level mode for codes 2, 3
	task automatic t_tach();
		for (int i = 0; i < 4; i++) begin
			u_host.wr(8'h05, {2'b01, i[0], 1'b0, i[0], i[1], i[1], 1'b0});
			cyc();
			np = 0;
			np2 = 0;
			repeat (8) begin
				@(negedge clk) t1 = 1'b1;
				@(negedge clk) t2 = 1'b1;
				@(negedge clk) t1 = 1'b0;
				@(negedge clk) t2 = 1'b0;
			end
			repeat (3) @(negedge clk);
			chk(16'(np), 16'(8 >> i));
			chk(16'(np2), 16'(i > 1 ? 0 : 8 >> i));
			chk(16'(ta[0]), 16'h0000);
			if (i > 1) begin
				chk(16'(ta[1]), 16'(i[0]));
				t2 = 1'b1;
				repeat (2) @(negedge clk);
				chk(16'(ta[1]), 16'(!i[0]));
				t2 = 1'b0;
			end
		end
	endtask
	task automatic t_pin();
		u_host.wr(8'h06, 8'h02);
		cyc();
		over = 1'b1;
		pk(8'h01);
		rc(8'h06, 8'h03);
		over = 1'b0;
		pk(8'h00);
		u_host.wr(8'h06, 8'h00);
		cyc();
		pk(8'h01);
		over = 1'b1;
		pk(8'h00);
		over = 1'b0;
		for (int i = 0; i < 2; i++) begin
			m2 = i[0];
			u_host.wr(8'h06, i[0] ? 8'h02 : 8'h06);
			cyc();
			@(negedge clk) over = 1'b1;
			@(negedge clk) over = 1'b0;
			pk(8'h01);
			ack = 1'b1;
			@(negedge clk) ack = 1'b0;
			pk(8'h00);
		end
		m2 = 1'b0;
		u_host.wr(8'h05, 8'h80);
		cyc();
		rreq = 1'b1;
		pk(8'h00);
		rreq = 1'b0;
		pk(8'h01);
		rc(8'h06, 8'h02);
		u_host.wr(8'h05, 8'hC0);
		cyc();
		repeat (2) @(negedge clk);
		chk(16'(oe_n), 16'h0001);
	endtask
	// fraction bits land in 7:4; eight-bit mode keeps only the top one
	task automatic t_temp();
		for (int i = 0; i < 2; i++) begin
			u_host.wr(8'h06, i[0] ? 8'h00 : 8'h08);
			cyc();
			repeat (2) @(negedge clk);
			chk(16'(hires), 16'(!i[0]));
			frac = 4'hA;
			twr = 1'b1;
			@(negedge clk) twr = 1'b0;
			rc(8'h06, i[0] ? 8'h80 : 8'hA8);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d fails %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// main sequence after two reset cycles
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_rate();
		t_tach();
		t_pin();
		t_temp();
		end_of_test();
	end
	// watchdog, well beyond the longest delayed cycle
	initial begin
		repeat (40000) @(negedge clk);
		fail_count++;
		end_of_test();
	end
endmodule // tb
`default_nettype wire
